// ===== shared/pi_lpf_params.svh
// Register map, field positions, reset values and timing counts
`ifndef PI_LPF_PARAMS_SVH
`define PI_LPF_PARAMS_SVH

// Byte addresses in the special function register space
`define ADDR_FILTER_COEF 8'hDD
`define ADDR_FILTER_IN 8'hDE
`define ADDR_FILTER_OUT 8'hE6
`define ADDR_REG_ERROR 8'hEA
`define ADDR_REG_OUTPUT 8'hEC
`define ADDR_PROP_GAIN 8'hEE
`define ADDR_INTEG_GAIN 8'hF2
`define ADDR_OUT_UPPER 8'hF4
`define ADDR_OUT_LOWER 8'hF6
`define ADDR_CTRL 8'hF9

// Word slots of the 16-bit register array
`define SLOT_FILTER_IN 3'h0
`define SLOT_FILTER_OUT 3'h1
`define SLOT_REG_ERROR 3'h2
`define SLOT_REG_OUTPUT 3'h3
`define SLOT_PROP_GAIN 3'h4
`define SLOT_INTEG_GAIN 3'h5
`define SLOT_OUT_UPPER 3'h6
`define SLOT_OUT_LOWER 3'h7

// Control register fields
`define FILTER_START_BIT 0
`define REG_START_BIT 1
`define GAIN_FORMAT_BIT 2

// Reset values
`define RST_WORD 16'h0000
`define RST_COEF 8'h00
`define RST_GAIN_FORMAT 1'b0
`define RST_COUNT 3'h0

// Cycles from the start bit being set to the result register update
`define CALC_CYCLES 3'h4

// Fraction bits of the fixed point formats
`define GAIN_Q12_SHIFT 12
`define GAIN_Q15_SHIFT 15
`define COEF_SHIFT 7

`endif

// ===== shared/pi_lpf_pkg.sv
// Types shared by the accelerator modules
package pi_lpf_pkg;
  typedef logic signed [15:0] q15_t;
  typedef logic signed [7:0] coef_t;
  typedef logic [2:0] slot_t;
endpackage

// ===== shared/calc_if.sv
// Operand and result bundle between register file and arithmetic datapath
`timescale 1ns/1ps
interface calc_if;
  import pi_lpf_pkg::*;
  q15_t error;
  q15_t error_prev;
  q15_t reg_out;
  q15_t prop_gain;
  q15_t integ_gain;
  q15_t upper;
  q15_t lower;
  logic gain_q15;
  coef_t coef;
  q15_t filt_in;
  q15_t filt_out;
  q15_t reg_result;
  q15_t filt_result;
  modport engine (
    input error, error_prev, reg_out, prop_gain, integ_gain, upper, lower,
    input gain_q15, coef, filt_in, filt_out,
    output reg_result, filt_result
  );
  modport ctrl (
    output error, error_prev, reg_out, prop_gain, integ_gain, upper, lower,
    output gain_q15, coef, filt_in, filt_out,
    input reg_result, filt_result
  );
endinterface

// ===== core/calc_datapath.sv
// Two-stage arithmetic for the regulator and the low-pass filter
`timescale 1ns/1ps
`include "pi_lpf_params.svh"
module calc_datapath
  import pi_lpf_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Operands and results
  calc_if.engine bus
);

  // Saturate a wide signed value to the 16-bit range
  function automatic q15_t sat16(input logic signed [35:0] v);
    if (v > 36'sh0_0000_7FFF)
      sat16 = 16'sh7FFF;
    else if (v < -36'sh0_0000_8000)
      sat16 = -16'sh8000;
    else
      sat16 = q15_t'(v[15:0]);
  endfunction

  logic signed [16:0] err_delta;
  logic signed [16:0] filt_delta;
  logic signed [33:0] prop_prod_reg;
  logic signed [31:0] integ_prod_reg;
  logic signed [24:0] filt_prod_reg;
  logic signed [34:0] reg_acc;
  logic signed [34:0] reg_scaled;
  logic signed [35:0] reg_full;
  logic signed [24:0] filt_scaled;
  logic signed [35:0] filt_full;
  q15_t reg_result_reg;
  q15_t filt_result_reg;

  assign err_delta = $signed({bus.error[15], bus.error})
    - $signed({bus.error_prev[15], bus.error_prev});
  assign filt_delta = $signed({bus.filt_in[15], bus.filt_in})
    - $signed({bus.filt_out[15], bus.filt_out});

  // Full precision products, registered to split the multiplier path
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prop_prod_reg <= '0;
      integ_prod_reg <= '0;
      filt_prod_reg <= '0;
    end
    else
    begin
      prop_prod_reg <= bus.prop_gain * err_delta;
      integ_prod_reg <= bus.integ_gain * bus.error;
      filt_prod_reg <= bus.coef * filt_delta;
    end
  end

  assign reg_acc = $signed({prop_prod_reg[33], prop_prod_reg})
    + $signed({{3{integ_prod_reg[31]}}, integ_prod_reg});
  // Truncating shift: rounds toward minus infinity, cheapest option
  assign reg_scaled = bus.gain_q15 ? (reg_acc >>> `GAIN_Q15_SHIFT)
    : (reg_acc >>> `GAIN_Q12_SHIFT);
  assign reg_full = $signed({{20{bus.reg_out[15]}}, bus.reg_out})
    + $signed({reg_scaled[34], reg_scaled});
  assign filt_scaled = filt_prod_reg >>> `COEF_SHIFT;
  assign filt_full = $signed({{20{bus.filt_out[15]}}, bus.filt_out})
    + $signed({{11{filt_scaled[24]}}, filt_scaled});

  // Upper limit is checked first; with crossed limits, values above upper yield upper, all others lower
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      reg_result_reg <= `RST_WORD;
    else if (reg_full > $signed({{20{bus.upper[15]}}, bus.upper}))
      reg_result_reg <= bus.upper;
    else if (reg_full < $signed({{20{bus.lower[15]}}, bus.lower}))
      reg_result_reg <= bus.lower;
    else
      reg_result_reg <= sat16(reg_full);
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      filt_result_reg <= `RST_WORD;
    else
      filt_result_reg <= sat16(filt_full);
  end

  assign bus.reg_result = reg_result_reg;
  assign bus.filt_result = filt_result_reg;

endmodule

// ===== core/pi_lpf_accelerator.sv
// Regulator and low-pass filter accelerator with its byte-wide register file
// Functional notes
// - Output = previous output + Kp*(error - previous error) + Ki*error.
// - Each regulator output is clamped between the upper and lower limits.
// - Regulator output register updates four cycles after its start bit sets.
// - Software sets regulator start at bit 1; hardware clears it when done.
// - Bit 2 picks gain format: 0 means Q12 (default), 1 means Q15.
// - Error, output and limits are always Q15 regardless of gain format.
// - Each calculation keeps its output and error for the next one.
// - Writing output replaces previous output; error becomes previous after start.
// - Error, output, gains and limits are 16-bit signed, reset to zero.
// - Filter output = previous output + coefficient*(input - previous output).
// - Filter output register updates four cycles after its start bit sets.
// - Software sets filter start at bit 0; hardware clears it when done.
// - Filter output feeds the next calculation; software writes replace it.
// - Filter coefficient is 8-bit signed, -128..127 mapping to -1..127/128.
// - Filter input and output are 16-bit signed, reset to zero.
// - All registers live in the special function register space.
`timescale 1ns/1ps
`include "pi_lpf_params.svh"
module pi_lpf_accelerator
  import pi_lpf_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Special function register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit
);

  // Map a byte address to a 16-bit word slot; bit 3 flags a match
  function automatic logic [3:0] word_decode(input logic [7:0] a);
    logic [7:0] even;
    even = {a[7:1], 1'b0};
    unique case (even)
      `ADDR_FILTER_IN: word_decode = {1'b1, `SLOT_FILTER_IN};
      `ADDR_FILTER_OUT: word_decode = {1'b1, `SLOT_FILTER_OUT};
      `ADDR_REG_ERROR: word_decode = {1'b1, `SLOT_REG_ERROR};
      `ADDR_REG_OUTPUT: word_decode = {1'b1, `SLOT_REG_OUTPUT};
      `ADDR_PROP_GAIN: word_decode = {1'b1, `SLOT_PROP_GAIN};
      `ADDR_INTEG_GAIN: word_decode = {1'b1, `SLOT_INTEG_GAIN};
      `ADDR_OUT_UPPER: word_decode = {1'b1, `SLOT_OUT_UPPER};
      `ADDR_OUT_LOWER: word_decode = {1'b1, `SLOT_OUT_LOWER};
      default: word_decode = 4'h0;
    endcase
  endfunction

  calc_if bus ();

  q15_t word_reg [8];
  q15_t error_prev_reg;
  coef_t coef_reg;
  logic gain_format_reg;
  logic [2:0] count_reg [2];
  logic [1:0] busy;
  logic [1:0] commit;
  logic [1:0] start_set;
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  logic word_wr;
  logic coef_wr;
  logic ctrl_wr;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  assign wr_sel = word_decode(i_sfr_addr);
  assign rd_sel = wr_sel;
  assign word_wr = i_sfr_wr && wr_sel[3];
  assign coef_wr = i_sfr_wr && (i_sfr_addr == `ADDR_FILTER_COEF);
  assign ctrl_wr = i_sfr_wr && (i_sfr_addr == `ADDR_CTRL);
  assign o_sfr_hit = wr_sel[3] || (i_sfr_addr == `ADDR_FILTER_COEF)
    || (i_sfr_addr == `ADDR_CTRL);

  // Start bits: software sets, the sequencer clears after the fixed latency
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_engine
      assign start_set[g] = ctrl_wr && i_sfr_wdata[g];
      assign busy[g] = (count_reg[g] != `RST_COUNT);
      assign commit[g] = (count_reg[g] == `CALC_CYCLES);
      // A new start in the commit cycle wins and restarts the count
      always_ff @(posedge i_clock or negedge i_rstn)
      begin
        if (!i_rstn)
          count_reg[g] <= `RST_COUNT;
        else if (start_set[g])
          count_reg[g] <= 3'h1;
        else if (commit[g])
          count_reg[g] <= `RST_COUNT;
        else if (busy[g])
          count_reg[g] <= count_reg[g] + 3'h1;
      end
    end
  endgenerate

  // 16-bit registers with byte access and hardware result commit
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < 8; i++)
        word_reg[i] <= `RST_WORD;
    end
    else
    begin
      if (commit[`REG_START_BIT])
        word_reg[`SLOT_REG_OUTPUT] <= bus.reg_result;
      if (commit[`FILTER_START_BIT])
        word_reg[`SLOT_FILTER_OUT] <= bus.filt_result;
      // Software write comes last so it overrides a same-cycle commit
      if (word_wr && !i_sfr_addr[0])
        word_reg[wr_sel[2:0]][7:0] <= i_sfr_wdata;
      if (word_wr && i_sfr_addr[0])
        word_reg[wr_sel[2:0]][15:8] <= i_sfr_wdata;
    end
  end

  // Previous error follows each finished regulator calculation only
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      error_prev_reg <= `RST_WORD;
    else if (commit[`REG_START_BIT])
      error_prev_reg <= word_reg[`SLOT_REG_ERROR];
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      coef_reg <= `RST_COEF;
    else if (coef_wr)
      coef_reg <= coef_t'(i_sfr_wdata);
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      gain_format_reg <= `RST_GAIN_FORMAT;
    else if (ctrl_wr)
      gain_format_reg <= i_sfr_wdata[`GAIN_FORMAT_BIT];
  end

  // Operands are read live; writes during a calculation may reach the result
  assign bus.error = word_reg[`SLOT_REG_ERROR];
  assign bus.error_prev = error_prev_reg;
  assign bus.reg_out = word_reg[`SLOT_REG_OUTPUT];
  assign bus.prop_gain = word_reg[`SLOT_PROP_GAIN];
  assign bus.integ_gain = word_reg[`SLOT_INTEG_GAIN];
  assign bus.upper = word_reg[`SLOT_OUT_UPPER];
  assign bus.lower = word_reg[`SLOT_OUT_LOWER];
  assign bus.gain_q15 = gain_format_reg;
  assign bus.coef = coef_reg;
  assign bus.filt_in = word_reg[`SLOT_FILTER_IN];
  assign bus.filt_out = word_reg[`SLOT_FILTER_OUT];

  calc_datapath u_datapath (
    .i_clock (i_clock),
    .i_rstn (i_rstn),
    .bus (bus.engine)
  );

  // Read mux; unmapped addresses and reserved bits return zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (rd_sel[3])
      rdata_next = i_sfr_addr[0] ? word_reg[rd_sel[2:0]][15:8]
        : word_reg[rd_sel[2:0]][7:0];
    else if (i_sfr_addr == `ADDR_FILTER_COEF)
      rdata_next = coef_reg;
    else if (i_sfr_addr == `ADDR_CTRL)
      rdata_next = {5'h00, gain_format_reg, busy};
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_reg <= 8'h00;
    else if (i_sfr_rd)
      rdata_reg <= rdata_next;
  end

  assign o_sfr_rdata = rdata_reg;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  AST_REG_LATENCY: assert property (
    commit[`REG_START_BIT] |-> $past(busy[`REG_START_BIT], 3)
  ) else $error("regulator committed without start three cycles before");

  AST_REG_START_RUN: assert property (
    ($rose(busy[`REG_START_BIT]) && !ctrl_wr) ##1 !ctrl_wr [*3]
      |-> ##1 !busy[`REG_START_BIT]
  ) else $error("regulator start bit not cleared after four cycles");

  AST_REG_CLAMP: assert property (
    $fell(busy[`REG_START_BIT]) && !$past(word_wr)
      && ($signed(bus.upper) >= $signed(bus.lower))
      |-> ($signed(bus.reg_out) <= $signed(bus.upper))
        && ($signed(bus.reg_out) >= $signed(bus.lower))
  ) else $error("regulator output outside its limits");

  AST_ERROR_PREV: assert property (
    commit[`REG_START_BIT] |=> error_prev_reg == $past(word_reg[`SLOT_REG_ERROR])
  ) else $error("previous error not taken from current error");

  AST_FILT_LATENCY: assert property (
    commit[`FILTER_START_BIT] |-> $past(busy[`FILTER_START_BIT], 3)
  ) else $error("filter committed without start three cycles before");

  AST_FILT_COMMIT: assert property (
    commit[`FILTER_START_BIT] && !word_wr
      |=> word_reg[`SLOT_FILTER_OUT] == $past(bus.filt_result)
  ) else $error("filter output not updated from datapath");

  AST_OUTPUT_WRITE: assert property (
    word_wr && (i_sfr_addr == `ADDR_REG_OUTPUT)
      |=> word_reg[`SLOT_REG_OUTPUT][7:0] == $past(i_sfr_wdata)
  ) else $error("software write to regulator output lost");

  AST_GAIN_FORMAT: assert property (
    ctrl_wr |=> gain_format_reg == $past(i_sfr_wdata[`GAIN_FORMAT_BIT])
      ##1 bus.gain_q15 == gain_format_reg
  ) else $error("gain format select not applied");

  AST_COUNT_BOUND: assert property (
    count_reg[`FILTER_START_BIT] <= `CALC_CYCLES
  ) else $error("filter sequencer count out of range");

  AST_READ_CTRL: assert property (
    i_sfr_rd && (i_sfr_addr == `ADDR_CTRL)
      |=> o_sfr_rdata[1:0] == $past(busy) && o_sfr_rdata[7:3] == 5'h00
  ) else $error("control register read does not show start bits");

  AST_FILT_START_RUN: assert property (
    ($rose(busy[`FILTER_START_BIT]) && !ctrl_wr) ##1 !ctrl_wr [*3]
      |-> ##1 !busy[`FILTER_START_BIT]
  ) else $error("filter start bit not cleared after four cycles");

  AST_REG_COMMIT: assert property (
    commit[`REG_START_BIT] && !word_wr
      |=> word_reg[`SLOT_REG_OUTPUT] == $past(bus.reg_result)
  ) else $error("regulator output not updated from datapath");

  AST_REG_START_SET: assert property (
    start_set[`REG_START_BIT] |=> count_reg[`REG_START_BIT] == 3'h1
  ) else $error("regulator start not taken");

  AST_RDATA_HOLD: assert property (
    !i_sfr_rd |=> $stable(o_sfr_rdata)
  ) else $error("read data changed without a read strobe");

  COV_REG_DONE: cover property (commit[`REG_START_BIT]);
  COV_FILT_DONE: cover property (commit[`FILTER_START_BIT]);
  COV_BOTH_DONE: cover property (commit == 2'h3);
  COV_FILT_RESTART: cover property (start_set[`FILTER_START_BIT] && busy[`FILTER_START_BIT]);
  COV_CLAMP_UPPER: cover property (
    commit[`REG_START_BIT] && (bus.reg_result == bus.upper)
      && (bus.upper != 16'h0000)
  );

endmodule

// ===== verification/sfr_host_model.sv
// Host-side driver for the byte-wide special function register bus
`timescale 1ns/1ps
`include "pi_lpf_params.svh"
module sfr_host_model
(
  // Clock
  input wire logic i_clock,
  // Register bus
  input wire logic [7:0] i_sfr_rdata,
  output logic [7:0] o_sfr_addr,
  output logic o_sfr_wr,
  output logic o_sfr_rd,
  output logic [7:0] o_sfr_wdata
);
  initial
  begin
    o_sfr_addr = 8'h00;
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_wdata = 8'h00;
  end

  // Called just after a rising edge; the idle edge keeps strobes from doubling up
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    o_sfr_addr <= a;
    o_sfr_wdata <= d;
    o_sfr_wr <= 1'b1;
    @(posedge i_clock);
    o_sfr_wr <= 1'b0;
    o_sfr_wdata <= ~d;
    @(posedge i_clock);
  endtask

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    o_sfr_addr <= a;
    o_sfr_rd <= 1'b1;
    @(posedge i_clock);
    o_sfr_rd <= 1'b0;
    @(posedge i_clock);
    d = i_sfr_rdata;
  endtask

  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    write_byte(a, d[7:0]);
    write_byte(a + 8'h01, d[15:8]);
  endtask

  task automatic read_word(input logic [7:0] a, output logic [15:0] d);
    read_byte(a, d[7:0]);
    read_byte(a + 8'h01, d[15:8]);
  endtask

  // Reload one loop's state when the regulator serves several loops
  task automatic restore_loop(input logic [15:0] e, input logic [15:0] u, input logic fmt);
    write_word(`ADDR_REG_ERROR, e);
    write_byte(`ADDR_CTRL, {5'h00, fmt, 2'b10});
    repeat (4) @(posedge i_clock);
    write_word(`ADDR_REG_OUTPUT, u);
  endtask
endmodule

// ===== verification/test_pi_lpf_accelerator.sv
// Self-checking bench for the regulator and filter accelerator
`timescale 1ns/1ps
`include "pi_lpf_params.svh"
module test_pi_lpf_accelerator;
  import pi_lpf_pkg::*;
  logic clock;
  logic rstn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic hit;
  logic fmt;
  logic [7:0] b;
  logic [15:0] w;
  q15_t kp, ki, hi, lo, up, ep, ye;
  coef_t k;
  logic [7:0] slots [8] = '{8'hDE, 8'hE6, 8'hEA, 8'hEC, 8'hEE, 8'hF2, 8'hF4, 8'hF6};
  int fail_count;
  int comparisons;

  pi_lpf_accelerator u_dut (.i_clock(clock), .i_rstn(rstn), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .o_sfr_hit(hit));
  sfr_host_model u_host (.i_clock(clock), .i_sfr_rdata(rdata), .o_sfr_addr(addr),
    .o_sfr_wr(wr), .o_sfr_rd(rd), .o_sfr_wdata(wdata));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One floor shift of the summed products, clamp with the upper limit tested first
  function automatic q15_t pi_next(input q15_t e);
    longint s;
    int sh;
    sh = fmt ? `GAIN_Q15_SHIFT : `GAIN_Q12_SHIFT;
    s = (longint'(kp) * (longint'(e) - longint'(ep))) + (longint'(ki) * longint'(e));
    s = longint'(up) + (s >>> sh);
    if (s > longint'(hi))
      s = longint'(hi);
    else if (s < longint'(lo))
      s = longint'(lo);
    return s[15:0];
  endfunction

  function automatic q15_t lpf_next(input q15_t x);
    longint s;
    s = longint'(ye) + ((longint'(k) * (longint'(x) - longint'(ye))) >>> `COEF_SHIFT);
    if (s > 32767)
      s = 32767;
    else if (s < -32768)
      s = -32768;
    return s[15:0];
  endfunction

  // Busy is read two edges after the start; a read on the fourth edge still sees busy,
  // so the done read waits one more edge
  task automatic run_calc(input logic [1:0] go, input logic [7:0] ra, input q15_t exp);
    u_host.write_byte(`ADDR_CTRL, {5'h00, fmt, go});
    u_host.read_byte(`ADDR_CTRL, b);
    check({8'h00, b}, {13'h0000, fmt, go}, "busy");
    @(posedge clock);
    u_host.read_byte(`ADDR_CTRL, b);
    check({8'h00, b}, {13'h0000, fmt, 2'b00}, "done");
    u_host.read_word(ra, w);
    check(w, exp, "result");
  endtask

  task automatic pi_step(input q15_t e);
    q15_t exp;
    exp = pi_next(e);
    u_host.write_word(`ADDR_REG_ERROR, e);
    run_calc(2'b10, `ADDR_REG_OUTPUT, exp);
    up = exp;
    ep = e;
  endtask

  task automatic lpf_step(input q15_t x);
    q15_t exp;
    exp = lpf_next(x);
    u_host.write_word(`ADDR_FILTER_IN, x);
    run_calc(2'b01, `ADDR_FILTER_OUT, exp);
    ye = exp;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    close_out();
  end

  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    fmt = 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int a = 'hDD; a <= 'hF9; a++)
    begin
      u_host.read_byte(a[7:0], b);
      check({8'h00, b}, 16'h0000, "reset byte");
    end
    u_host.read_byte(8'hF0, b);
    check({15'h0000, hit}, 16'h0000, "unmapped hit");
    u_host.read_byte(`ADDR_REG_ERROR, b);
    check({15'h0000, hit}, 16'h0001, "mapped hit");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      u_host.write_word(slots[i], 16'hA5C3 ^ 16'(i));
      u_host.read_word(slots[i], w);
      check(w, 16'hA5C3 ^ 16'(i), "word");
    end
    u_host.write_byte(`ADDR_FILTER_COEF, 8'h5A);
    u_host.read_byte(`ADDR_FILTER_COEF, b);
    check({8'h00, b}, 16'h005A, "coefficient");
    u_host.write_byte(`ADDR_CTRL, 8'hFC);
    u_host.read_byte(`ADDR_CTRL, b);
    check({8'h00, b}, 16'h0004, "control");
    u_host.write_byte(`ADDR_CTRL, 8'h00);
    $display("test access done");
    kp = 16'h1000;
    ki = 16'h0800;
    hi = 16'h2000;
    lo = 16'hE000;
    up = 16'h0000;
    ep = 16'h0000;
    u_host.write_word(`ADDR_PROP_GAIN, kp);
    u_host.write_word(`ADDR_INTEG_GAIN, ki);
    u_host.write_word(`ADDR_OUT_UPPER, hi);
    u_host.write_word(`ADDR_OUT_LOWER, lo);
    u_host.write_word(`ADDR_REG_OUTPUT, up);
    pi_step(16'sd100);
    pi_step(16'sd40);
    pi_step(16'sd10000);
    pi_step(-16'sd20000);
    fmt = 1'b1;
    kp = 16'h4000;
    ki = 16'h2000;
    u_host.write_word(`ADDR_PROP_GAIN, kp);
    u_host.write_word(`ADDR_INTEG_GAIN, ki);
    u_host.restore_loop(16'h0000, 16'h0000, fmt);
    up = 16'h0000;
    ep = 16'h0000;
    pi_step(16'sd400);
    pi_step(-16'sd1000);
    $display("test regulator done");
    k = 8'h40;
    ye = 16'sd100;
    u_host.write_byte(`ADDR_FILTER_COEF, k);
    u_host.write_word(`ADDR_FILTER_OUT, ye);
    lpf_step(16'sd300);
    lpf_step(16'sd300);
    k = 8'h80;
    ye = 16'h4000;
    u_host.write_byte(`ADDR_FILTER_COEF, k);
    u_host.write_word(`ADDR_FILTER_OUT, ye);
    lpf_step(16'hC000);
    // A second start two edges after the first restarts the four-cycle count
    k = 8'h20;
    u_host.write_byte(`ADDR_FILTER_COEF, k);
    u_host.write_byte(`ADDR_CTRL, {5'h00, fmt, 2'b01});
    u_host.write_byte(`ADDR_CTRL, {5'h00, fmt, 2'b01});
    u_host.read_byte(`ADDR_CTRL, b);
    u_host.read_byte(`ADDR_CTRL, b);
    check({8'h00, b}, {13'h0000, fmt, 2'b01}, "restart busy");
    u_host.read_word(`ADDR_FILTER_OUT, w);
    check(w, lpf_next(16'hC000), "restart result");
    $display("test filter done");
    close_out();
  end
endmodule
